// ==== include/lorc_pkg.sv ====
/*
  Shared constants for the LED string overvoltage recovery controller:
  timing figures, register map, field positions and the state encoding.
  Assumes a single 25 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package lorc_pkg;

  // System clock rate and the two windows in their printed units.
  localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
  localparam int unsigned HOLD_TIME_US  = 5000;
  localparam int unsigned RECOV_TIME_US = 5000;

  // Cycle counts derived from the times above.
  localparam int unsigned HOLD_CYC  = HOLD_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned RECOV_CYC = RECOV_TIME_US * (CLK_FREQ_HZ / 1_000_000);

  // Register byte addresses.
  localparam logic [3:0] ADDR_STATUS_ONE = 4'h0;
  localparam logic [3:0] ADDR_SUMMARY    = 4'h4;
  localparam logic [3:0] ADDR_CONTROL    = 4'h8;
  localparam logic [3:0] ADDR_LIVE       = 4'hc;

  // Field positions of status_word_one.
  localparam int unsigned STAT_OV_BIT  = 18;
  localparam int unsigned STAT_OC_BIT  = 17;
  localparam int unsigned STAT_REC_BIT = 16;

  // Field positions of summary_status_byte.
  localparam int unsigned SUM_OV_BIT = 7;
  localparam int unsigned SUM_OC_BIT = 4;

  // Field positions and reset value of the control register.
  localparam int unsigned CTL_DITHER_BIT = 0;
  localparam int unsigned CTL_STOP_BIT   = 1;
  localparam logic [1:0]  CTL_RST        = 2'h0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Supervisor states.
  typedef enum logic [2:0] {
    ST_UNDERV    = 3'h0,
    ST_HOLD      = 3'h1,
    ST_RECOV     = 3'h2,
    ST_RECOV_DIS = 3'h3,
    ST_NORMAL    = 3'h4,
    ST_FAULT     = 3'h5
  } lorc_state_t;

endpackage

// ==== rtl/lorc_timer.sv ====
/*
  Saturating cycle counter used for the start-up hold window and for the
  accumulated recovery window. Assumes synchronous inputs on aclk.
*/
`timescale 1ns/1ns
module lorc_timer #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned WIDTH = $clog2(LIMIT + 1)
) (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control.
  input  wire logic clear,
  input  wire logic run,
  // Status.
  output logic      done_q
);

  localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

  logic [WIDTH-1:0] count_q;  // Cycles counted so far.
  logic [WIDTH-1:0] count_d;  // Next count.
  logic             done_d;   // Next done flag.

  // Counting only advances while run is high, so short runs accumulate.
  always_comb begin
    count_d = count_q;
    done_d  = done_q;
    if (clear) begin
      count_d = '0;
      done_d  = 1'b0;
    end else if (run && !done_q) begin
      if (count_q == LAST) begin
        done_d = 1'b1;
      end else begin
        count_d = count_q + WIDTH'(1);
      end
    end
  end

  // Registers only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      done_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      done_q  <= done_d;
    end
  end

endmodule

// ==== rtl/lorc_top.sv ====
/*
  LED string overvoltage and overcurrent supervisor with an AXI4-Lite
  register slave. Comparator levels and the dimming PWM input are taken
  as synchronous to aclk; converter, dimming switch and discharge
  controls go to the analog power stage.
*/
`timescale 1ns/1ns
// Operation
// - Dither off by default, strap high enables.
// - Supply below minimum keeps recovery flag set.
// - Hold window keeps converter stopped, ignoring PWM.
// - After hold window, follow PWM if fault-free.
// - Clean recovery window clears recovery flag.
// - Later overvoltage latches, stops until read-clear.
// - Overvoltage in recovery: discharge, then self-release.
// - Recovery window starts at late PWM rise.
// - Normal overvoltage latches, discharges, stops until cleared.
// - Supply overvoltage inhibits discharge and flag.
// - Overvoltage outlasting supply overvoltage then latches.
// - Recovery time accumulates over short PWM pulses.
// - Overvoltage stops converter, switch; flags; discharges.
// - Overcurrent sets flag, stops converter and switch.
// - Restart needs release level and cleared flag.
// - Overvoltage shown in summary and status words.
module lorc_top
  import lorc_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES  = HOLD_CYC,
  parameter int unsigned RECOV_CYCLES = RECOV_CYC
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data.
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response.
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read.
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Comparators, straps and dimming input.
  input  wire logic        supply_above_min,
  input  wire logic        supply_overvoltage,
  input  wire logic        string_above_trip,
  input  wire logic        string_above_release,
  input  wire logic        overcurrent_trip,
  input  wire logic        dim_pwm_in,
  input  wire logic        sdi_strap,
  // Power stage controls.
  output logic             converter_run_q,
  output logic             dimming_switch_q,
  output logic             discharge_q,
  output logic             dither_enable_q
);

  // Supervisor state and flags.
  lorc_state_t state_q, state_d;
  logic        rec_flag_q, rec_flag_d;     // ovp_recovery_flag.
  logic        ov_flag_q, ov_flag_d;       // string_overvoltage_flag.
  logic        oc_flag_q, oc_flag_d;       // string_overcurrent_flag.
  logic        run_d, dim_d, dis_d, dith_d;
  logic        strap_seen_q, strap_seen_d; // Strap already sampled.
  logic        strap_q, strap_d;           // Sampled strap level.
  logic [1:0]  ctl_q, ctl_d;               // Control register.
  logic        hold_done, rec_done;        // Timer results.
  logic        ov_event;                   // Qualified string overvoltage.
  logic        rc_read;                    // Read-and-clear taken.

  // Write channel state.
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [3:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        awready_d, wready_d, bvalid_d;
  logic [1:0]  bresp_d;
  logic        wr_fire;

  // Read channel state.
  logic        arready_d, rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_d;
  logic        ar_take;

  // A string overvoltage only counts while the supply is not over
  // voltage; the power stage is already off then anyway.
  assign ov_event = string_above_trip && !supply_overvoltage;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign rc_read  = ar_take && (s_axi_araddr == ADDR_STATUS_ONE);
  assign wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;

  // Hold window timer, restarted whenever the supply drops.
  lorc_timer #(.LIMIT(HOLD_CYCLES)) u_hold (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (state_q == ST_UNDERV),
    .run     (state_q == ST_HOLD),
    .done_q  (hold_done)
  );

  // Recovery timer runs only while PWM is high, so it starts at the
  // first PWM rise and sums short on-times.
  lorc_timer #(.LIMIT(RECOV_CYCLES)) u_recov (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (state_q == ST_UNDERV || state_q == ST_HOLD),
    .run     (state_q == ST_RECOV && dim_pwm_in),
    .done_q  (rec_done)
  );

  // Supervisor next state, flags and power stage controls.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_UNDERV: begin
        if (supply_above_min) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (hold_done) begin
          state_d = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (ov_event) begin
          state_d = ST_RECOV_DIS;
        end else if (rec_done) begin
          state_d = ST_NORMAL;
        end
      end
      ST_RECOV_DIS: begin
        if (!string_above_release && !ov_event) begin
          state_d = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (ov_event || overcurrent_trip) begin
          state_d = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // Both the level and the software clear are needed.
        if (!ov_flag_q && !oc_flag_q && !string_above_release) begin
          state_d = ST_NORMAL;
        end
      end
      default: state_d = ST_UNDERV;
    endcase
    if (!supply_above_min) begin
      state_d = ST_UNDERV;
    end
    rec_flag_d = (state_d != ST_NORMAL) && (state_d != ST_FAULT);
    // Set wins over the read-and-clear in the same cycle.
    ov_flag_d = (ov_flag_q && !rc_read) || ov_event;
    oc_flag_d = (oc_flag_q && !rc_read) || overcurrent_trip;
    // Converter follows PWM only in running states and fault-free.
    run_d = dim_pwm_in && !ctl_q[CTL_STOP_BIT] && !supply_overvoltage
            && !ov_event && !overcurrent_trip
            && (state_q == ST_RECOV || state_q == ST_NORMAL)
            && (state_d == ST_RECOV || state_d == ST_NORMAL);
    dim_d = run_d;
    // Discharge until release level, never during supply overvoltage.
    dis_d = !supply_overvoltage && (ov_event || (string_above_release
            && (state_d == ST_RECOV_DIS || state_d == ST_FAULT)));
    // Strap is sampled once, in the first cycle after reset release.
    strap_seen_d = 1'b1;
    strap_d      = strap_seen_q ? strap_q : sdi_strap;
    dith_d = strap_d || ctl_q[CTL_DITHER_BIT];
  end

  // Supervisor registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q          <= ST_UNDERV;
      rec_flag_q       <= 1'b1;
      ov_flag_q        <= 1'b0;
      oc_flag_q        <= 1'b0;
      converter_run_q  <= 1'b0;
      dimming_switch_q <= 1'b0;
      discharge_q      <= 1'b0;
      dither_enable_q  <= 1'b0;
      strap_seen_q     <= 1'b0;
      strap_q          <= 1'b0;
    end else begin
      state_q          <= state_d;
      rec_flag_q       <= rec_flag_d;
      ov_flag_q        <= ov_flag_d;
      oc_flag_q        <= oc_flag_d;
      converter_run_q  <= run_d;
      dimming_switch_q <= dim_d;
      discharge_q      <= dis_d;
      dither_enable_q  <= dith_d;
      strap_seen_q     <= strap_seen_d;
      strap_q          <= strap_d;
    end
  end

  // Write channel: address and data taken in either order, then a
  // response one cycle after both are held.
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    ctl_d     = ctl_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      if (aw_addr_q == ADDR_CONTROL) begin
        if (w_strb_q[0]) begin
          ctl_d = w_data_q[1:0];
        end
      end else if (aw_addr_q != ADDR_STATUS_ONE
                   && aw_addr_q != ADDR_SUMMARY
                   && aw_addr_q != ADDR_LIVE) begin
        bresp_d = RESP_SLVERR; // Unmapped address.
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  // Write channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      ctl_q         <= CTL_RST;
    end else begin
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      aw_addr_q     <= aw_addr_d;
      w_data_q      <= w_data_d;
      w_strb_q      <= w_strb_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      ctl_q         <= ctl_d;
    end
  end

  // Read channel: one read at a time, data one cycle after the address.
  // The status word is sampled before its flags are cleared.
  always_comb begin
    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0;
      rresp_d  = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_STATUS_ONE: begin
          rdata_d[STAT_OV_BIT]  = ov_flag_q;
          rdata_d[STAT_OC_BIT]  = oc_flag_q;
          rdata_d[STAT_REC_BIT] = rec_flag_q;
        end
        ADDR_SUMMARY: begin
          rdata_d[SUM_OV_BIT] = ov_flag_q;
          rdata_d[SUM_OC_BIT] = oc_flag_q;
        end
        ADDR_CONTROL: rdata_d[1:0] = ctl_q;
        ADDR_LIVE:    rdata_d[3:0] = {dither_enable_q, state_q};
        default:      rresp_d = RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  // Read channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
      s_axi_arready <= arready_d;
    end
  end

  // Checks on the supervisor.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A clean recovery: window done, then flag drops one cycle later.
  sequence s_clean_recov;
    state_q == ST_RECOV && rec_done && !string_above_trip
      && supply_above_min;
  endsequence
  sequence s_rec_cleared;
    state_q == ST_NORMAL && !rec_flag_q;
  endsequence

  a_underv_flag: assert property (
    !supply_above_min |=> rec_flag_q && state_q == ST_UNDERV)
    else $error("Recovery flag not held under low supply.");
  a_hold_stop: assert property (
    state_q == ST_HOLD |=> !converter_run_q)
    else $error("Converter ran during hold window.");
  a_hold_release: assert property (
    state_q == ST_HOLD && hold_done && supply_above_min
      |=> state_q == ST_RECOV)
    else $error("Hold window end did not release converter.");
  a_recov_clear: assert property (
    s_clean_recov |=> s_rec_cleared)
    else $error("Recovery flag not cleared after clean window.");
  a_fault_latch: assert property (
    state_q == ST_FAULT && ov_flag_q |=> !converter_run_q)
    else $error("Converter ran with latched overvoltage.");
  a_ov_stop: assert property (
    ov_event |=> !converter_run_q && !dimming_switch_q && ov_flag_q
      && discharge_q)
    else $error("Overvoltage did not stop and discharge.");
  a_oc_stop: assert property (
    overcurrent_trip |=> !converter_run_q && oc_flag_q)
    else $error("Overcurrent did not stop converter.");
  a_supply_ov_inhibit: assert property (
    supply_overvoltage && !ov_flag_q |=> !discharge_q && !ov_flag_q)
    else $error("Discharge or flag during supply overvoltage.");
  a_rc_clear: assert property (
    rc_read && !ov_event |=> !ov_flag_q && s_axi_rvalid)
    else $error("Read-and-clear left overvoltage flag set.");
  a_fault_restart: assert property (
    state_q == ST_FAULT && (ov_flag_q || string_above_release)
      |=> !converter_run_q && state_q != ST_NORMAL)
    else $error("Restart before flag clear and release.");
  a_strap_dither: assert property (
    strap_seen_q && strap_q |-> ##[1:2] dither_enable_q)
    else $error("Strap did not enable dither.");

endmodule

// ==== bench/lorc_stage_model.sv ====
/*
  Behavioural power stage: a string voltage level that jumps above the
  trip point on request and falls while the discharge load is on.
  Assumes the controller's outputs are registered on aclk.
*/
`timescale 1ns/1ns
module lorc_stage_model (
  // Clock.
  input  wire logic aclk,
  // Controls from the supervisor and the bench.
  input  wire logic discharge_q,
  input  wire logic ov_inject,
  // Comparator levels back to the supervisor.
  output logic      string_above_trip,
  output logic      string_above_release
);
  int lvl = 0; // Level in arbitrary steps.

  // The load drains one step a cycle; slow enough to read flags meanwhile.
  always_ff @(posedge aclk) begin
    if (ov_inject) begin
      lvl <= 40;
    end else if (discharge_q && lvl > 0) begin
      lvl <= lvl - 1;
    end
  end

  // Comparators: trip at 40 steps, release below 9 steps.
  assign string_above_trip    = (lvl >= 40);
  assign string_above_release = (lvl > 8);
endmodule

// ==== bench/tb.sv ====
/*
  Self-checking bench for the overvoltage recovery controller.
  Assumes the design package and short hold and recovery windows.
*/
`timescale 1ns/1ns
module tb;
  import lorc_pkg::*;
  localparam int unsigned HOLD = 20; // Short hold window.
  localparam int unsigned REC  = 30; // Short recovery window.
  logic aclk = 0, aresetn = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic supply_above_min = 0, supply_overvoltage = 0, overcurrent_trip = 0;
  logic dim_pwm_in = 0, sdi_strap = 0, ov_inject = 0;
  logic string_above_trip, string_above_release;
  logic converter_run_q, dimming_switch_q, discharge_q, dither_enable_q;
  int failures = 0, n_checks = 0;
  logic [31:0] d;
  logic [1:0] r;

  lorc_top #(.HOLD_CYCLES(HOLD), .RECOV_CYCLES(REC)) lorc_top_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .supply_above_min, .supply_overvoltage,
    .string_above_trip, .string_above_release, .overcurrent_trip,
    .dim_pwm_in, .sdi_strap, .converter_run_q, .dimming_switch_q,
    .discharge_q, .dither_enable_q);

  lorc_stage_model lorc_stage_model_i (.aclk, .discharge_q, .ov_inject,
    .string_above_trip, .string_above_release);

  // Free-running 25 MHz clock.
  initial begin
    forever #20 aclk = ~aclk;
  end

  // Compare one value and count it.
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Let n edges pass, then sample where outputs have settled.
  task automatic tick(int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // AXI4-Lite write; each channel released when its ready is seen.
  task automatic wr(logic [3:0] a, logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1;
    s_axi_wdata <= v; s_axi_wstrb <= 4'hf; s_axi_bready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp; s_axi_bready <= 0; break;
      end
    end
  endtask

  // AXI4-Lite read; data taken at the edge where rvalid is seen.
  task automatic rd(logic [3:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge aclk);
    s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0; break;
      end
    end
  endtask

  // Pulse the stage model into an overvoltage for one cycle.
  task automatic inject();
    @(posedge aclk); ov_inject <= 1;
    @(posedge aclk); ov_inject <= 0;
  endtask

  // Bounded wait for the string to drop below the release level.
  task automatic wait_rel();
    for (int i = 0; i < 200 && string_above_release; i++) tick(1);
  endtask

  // Hold reset for five cycles with the given strap level.
  task automatic do_reset(logic strap);
    @(posedge aclk);
    aresetn <= 0; supply_above_min <= 0; sdi_strap <= strap;
    dim_pwm_in <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    tick(3);
  endtask

  // Idle after reset, register bus refusals and the control register.
  task automatic t_idle();
    chk("dither", dither_enable_q, 0);
    rd(ADDR_STATUS_ONE, d, r);
    chk("rec", d[STAT_REC_BIT], 1);
    rd(4'h3, d, r);
    chk("rresp", r, RESP_SLVERR);
    wr(4'h3, 32'h1, r);
    chk("bresp", r, RESP_SLVERR);
    wr(ADDR_CONTROL, 32'h1, r);
    chk("bresp", r, RESP_OKAY);
    tick(2);
    chk("dither", dither_enable_q, 1);
    rd(ADDR_LIVE, d, r);
    chk("live", d, {28'h0, 1'b1, ST_UNDERV});
    rd(ADDR_CONTROL, d, r);
    chk("ctl", d, 32'h1);
    wr(ADDR_CONTROL, 32'h0, r);
    tick(2);
    chk("run", converter_run_q, 0);
  endtask

  // Late PWM rise and short pulses accumulating the recovery time.
  task automatic t_start();
    @(posedge aclk); supply_above_min <= 1;
    tick(HOLD - 5);
    chk("run", converter_run_q, 0);
    tick(20);
    rd(ADDR_STATUS_ONE, d, r);
    chk("rec", d[STAT_REC_BIT], 1);
    for (int p = 0; p < 3; p++) begin
      if (p == 2) begin
        rd(ADDR_STATUS_ONE, d, r);
        chk("rec", d[STAT_REC_BIT], 1);
      end
      @(posedge aclk); dim_pwm_in <= 1;
      tick(3);
      chk("run", converter_run_q, 1);
      chk("switch", dimming_switch_q, 1);
      tick(9);
      @(posedge aclk); dim_pwm_in <= 0;
      tick(3);
      chk("run", converter_run_q, 0);
    end
    rd(ADDR_STATUS_ONE, d, r);
    chk("rec", d[STAT_REC_BIT], 0);
    @(posedge aclk); dim_pwm_in <= 1;
  endtask

  // Overvoltage in normal run: stop, discharge, restart only when clear.
  task automatic t_ov();
    inject();
    tick(2);
    chk("run", converter_run_q, 0);
    chk("switch", dimming_switch_q, 0);
    chk("discharge", discharge_q, 1);
    rd(ADDR_SUMMARY, d, r);
    chk("sum_ov", d[SUM_OV_BIT], 1);
    rd(ADDR_STATUS_ONE, d, r);
    chk("ov", d[STAT_OV_BIT], 1);
    chk("run", converter_run_q, 0);
    wait_rel();
    tick(3);
    chk("discharge", discharge_q, 0);
    chk("run", converter_run_q, 1);
    rd(ADDR_STATUS_ONE, d, r);
    chk("ov", d[STAT_OV_BIT], 0);
  endtask

  // Overcurrent trip.
  task automatic t_oc();
    @(posedge aclk); overcurrent_trip <= 1;
    @(posedge aclk); overcurrent_trip <= 0;
    tick(1);
    chk("run", converter_run_q, 0);
    chk("switch", dimming_switch_q, 0);
    rd(ADDR_SUMMARY, d, r);
    chk("sum_oc", d[SUM_OC_BIT], 1);
    rd(ADDR_STATUS_ONE, d, r);
    chk("oc", d[STAT_OC_BIT], 1);
    tick(3);
    chk("run", converter_run_q, 1);
    // Software force stop overrides the PWM input, then releases it.
    wr(ADDR_CONTROL, 32'h1 << CTL_STOP_BIT, r);
    tick(2);
    chk("run", converter_run_q, 0);
    wr(ADDR_CONTROL, 32'h0, r);
    tick(2);
    chk("run", converter_run_q, 1);
  endtask

  // String overvoltage while the supply is over its limit.
  task automatic t_supov();
    @(posedge aclk); supply_overvoltage <= 1;
    inject();
    tick(3);
    chk("discharge", discharge_q, 0);
    rd(ADDR_SUMMARY, d, r);
    chk("sum_ov", d[SUM_OV_BIT], 0);
    @(posedge aclk); supply_overvoltage <= 0;
    tick(3);
    chk("discharge", discharge_q, 1);
    wait_rel();
    tick(3);
    chk("run", converter_run_q, 0);
    rd(ADDR_STATUS_ONE, d, r);
    chk("ov", d[STAT_OV_BIT], 1);
    tick(3);
    chk("run", converter_run_q, 1);
  endtask

  // Overvoltage inside the recovery window releases by itself.
  task automatic t_recov();
    do_reset(1);
    chk("dither", dither_enable_q, 1);
    @(posedge aclk); supply_above_min <= 1; dim_pwm_in <= 1;
    tick(HOLD - 5);
    chk("run", converter_run_q, 0);
    tick(10);
    chk("run", converter_run_q, 1);
    inject();
    tick(2);
    chk("discharge", discharge_q, 1);
    rd(ADDR_STATUS_ONE, d, r);
    chk("rec", d[STAT_REC_BIT], 1);
    wait_rel();
    tick(3);
    chk("run", converter_run_q, 1);
    rd(ADDR_STATUS_ONE, d, r);
    chk("rec", d[STAT_REC_BIT], 0);
  endtask

  // Print the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under 3000 cycles.
  initial begin
    #(40 * 20000);
    failures++;
    stop_test();
  end

  // Main sequence.
  initial begin
    do_reset(0);
    t_idle();
    t_start();
    t_ov();
    t_oc();
    t_supov();
    t_recov();
    stop_test();
  end
endmodule
